// [src/sync_framer_defines.vh]
`ifndef SYNC_FRAMER_DEFINES_VH
`define SYNC_FRAMER_DEFINES_VH

// Word and lane geometry
`define WORD_W 10
`define LANES 4
`define LANE_BUS_W 40
`define ROW_W 11
`define CNT_W 10
`define FIFO_DEPTH 8
`define FIFO_AW 3

// Register indices on the configuration port
`define IDX_TRAIN_PATTERN 8'h82
`define IDX_MARKER_IDENT 8'h83
`define IDX_BLACK_CODE 8'h84
`define IDX_PIXEL_CODE 8'h85
`define IDX_CHECKSUM_CODE 8'h86
`define IDX_TRAIN_CODE 8'h87
`define IDX_ROW_STATUS 8'h88

// Register reset values (wide word form)
`define RST_TRAIN_PATTERN 10'h3A6
`define RST_MARKER_IDENT 7'h2A
`define RST_BLACK_CODE 10'h015
`define RST_PIXEL_CODE 10'h035
`define RST_CHECKSUM_CODE 10'h059
`define RST_TRAIN_CODE 10'h3A6

// Boundary kinds, sync word bits 9:7 wide, 7:5 narrow
`define KIND_FRAME_BEGIN 3'h5
`define KIND_FRAME_FINISH 3'h6
`define KIND_LINE_BEGIN 3'h1
`define KIND_LINE_FINISH 3'h2

// Window numbers of the two readout windows
`define WIN_A_ID 3'h0
`define WIN_B_ID 3'h1

// Lane bit rates in Mbps for each word mode
`define RATE_WIDE_MBPS 10'h26C
`define RATE_NARROW_MBPS 10'h1F0

// Per-lane checksum generator
`define CRC_POLY 10'h233
`define CRC_SEED 10'h3FF

`endif

// [src/word_fifo.v]
`timescale 1ns/1ns
// Small flop-based FIFO with valid/ready on both sides
module word_fifo #(
  parameter W = 40,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock, enable, reset
  input wire clk,
  input wire ce,
  input wire srst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count
  assign in_ready = (count != D[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  //////////////////////////////////////////////////////////////////////////////
  // Storage write and pointer update
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // word_fifo

// [src/image_sync_channel_framer.v]
`timescale 1ns/1ns
`include "sync_framer_defines.vh"

module image_sync_channel_framer (
  // Clock, enable, reset
  input wire clk,
  input wire ce,
  input wire srst,
  // Forwarded word clock from the serialiser side
  input wire word_clk,
  // Configuration register port
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [9:0] reg_wdata,
  output wire [9:0] reg_rdata,
  // Readout control
  input wire narrow_mode,
  input wire frame_start,
  input wire [`CNT_W-1:0] black_lines,
  input wire [`CNT_W-1:0] line_words,
  input wire window_b_enable,
  input wire [`ROW_W-1:0] window_a_first_row,
  input wire [`ROW_W-1:0] window_a_last_row,
  input wire [`ROW_W-1:0] window_b_first_row,
  input wire [`ROW_W-1:0] window_b_last_row,
  // Pixel stream, four lanes packed lane0 in the low bits
  input wire pixel_valid,
  output wire pixel_ready,
  input wire [`LANE_BUS_W-1:0] pixel_data,
  // Serial lane words
  output wire [`WORD_W-1:0] lane0_word,
  output wire [`WORD_W-1:0] lane1_word,
  output wire [`WORD_W-1:0] lane2_word,
  output wire [`WORD_W-1:0] lane3_word,
  output wire [`WORD_W-1:0] sync_word,
  output wire word_strobe,
  output wire frame_active,
  output wire [9:0] lane_rate_mbps
);

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_NEXT = 8'h02;
  localparam [7:0] S_BEGIN = 8'h04;
  localparam [7:0] S_BID = 8'h08;
  localparam [7:0] S_DATA = 8'h10;
  localparam [7:0] S_FIN = 8'h20;
  localparam [7:0] S_FID = 8'h40;
  localparam [7:0] S_CRC = 8'h80;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Narrow mode keeps config bits 9:2 in the low byte
  function [`WORD_W-1:0] fmt;
    input narrow;
    input [`WORD_W-1:0] w;
    begin
      fmt = narrow ? {2'b00, w[9:2]} : w;
    end
  endfunction

  // One checksum step over a formatted lane word
  function [`WORD_W-1:0] crc_step;
    input [`WORD_W-1:0] c;
    input [`WORD_W-1:0] w;
    integer i;
    reg [`WORD_W-1:0] r;
    begin
      r = c;
      for (i = `WORD_W - 1; i >= 0; i = i - 1) begin
        if (r[`WORD_W-1] ^ w[i]) begin
          r = {r[`WORD_W-2:0], 1'b0} ^ `CRC_POLY;
        end else begin
          r = {r[`WORD_W-2:0], 1'b0};
        end
      end
      crc_step = r;
    end
  endfunction

  // Row lies inside a window
  function in_win;
    input [`ROW_W-1:0] row;
    input [`ROW_W-1:0] first;
    input [`ROW_W-1:0] last;
    begin
      in_win = (row >= first) && (row <= last);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Word clock synchroniser and edge finder

  reg wclk_s1;
  reg wclk_s2;
  reg wclk_s3;
  reg wclk_level;
  wire tick;

  // A level counts only once the second and third stages agree
  always @(posedge clk) begin
    if (srst) begin
      wclk_s1 <= 1'b0;
      wclk_s2 <= 1'b0;
      wclk_s3 <= 1'b0;
      wclk_level <= 1'b0;
    end else if (ce) begin
      wclk_s1 <= word_clk;
      wclk_s2 <= wclk_s1;
      wclk_s3 <= wclk_s2;
      if (wclk_s2 == wclk_s3) begin
        wclk_level <= wclk_s3;
      end
    end
  end

  assign tick = ce & (wclk_s2 == wclk_s3) & wclk_s3 & ~wclk_level;
  assign word_strobe = tick;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg [9:0] train_pattern;
  reg [6:0] frame_marker_ident_code;
  reg [9:0] black_type_code;
  reg [9:0] pixel_type_code;
  reg [9:0] checksum_type_code;
  reg [9:0] training_type_code;
  reg [9:0] rdata_q;
  reg [`ROW_W-1:0] row;

  // Writes land at the documented indices; others are dropped
  always @(posedge clk) begin
    if (srst) begin
      train_pattern <= `RST_TRAIN_PATTERN;
      frame_marker_ident_code <= `RST_MARKER_IDENT;
      black_type_code <= `RST_BLACK_CODE;
      pixel_type_code <= `RST_PIXEL_CODE;
      checksum_type_code <= `RST_CHECKSUM_CODE;
      training_type_code <= `RST_TRAIN_CODE;
    end else if (ce && reg_write) begin
      case (reg_addr)
        `IDX_TRAIN_PATTERN: train_pattern <= reg_wdata;
        `IDX_MARKER_IDENT: frame_marker_ident_code <= reg_wdata[6:0];
        `IDX_BLACK_CODE: black_type_code <= reg_wdata;
        `IDX_PIXEL_CODE: pixel_type_code <= reg_wdata;
        `IDX_CHECKSUM_CODE: checksum_type_code <= reg_wdata;
        `IDX_TRAIN_CODE: training_type_code <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Registered read; unmapped indices read zero
  always @(posedge clk) begin
    if (srst) begin
      rdata_q <= 10'h000;
    end else if (ce) begin
      case (reg_addr)
        `IDX_TRAIN_PATTERN: rdata_q <= train_pattern;
        `IDX_MARKER_IDENT: rdata_q <= {3'b000, frame_marker_ident_code};
        `IDX_BLACK_CODE: rdata_q <= black_type_code;
        `IDX_PIXEL_CODE: rdata_q <= pixel_type_code;
        `IDX_CHECKSUM_CODE: rdata_q <= checksum_type_code;
        `IDX_TRAIN_CODE: rdata_q <= training_type_code;
        `IDX_ROW_STATUS: rdata_q <= row[9:0];
        default: rdata_q <= 10'h000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Pixel FIFO

  wire fifo_valid;
  wire fifo_pop;
  wire [`LANE_BUS_W-1:0] fifo_data;

  word_fifo #(
    .W(`LANE_BUS_W),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .ce(ce),
    .srst(srst),
    .in_valid(pixel_valid),
    .in_ready(pixel_ready),
    .in_data(pixel_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Window geometry of the current row

  reg [7:0] state;
  reg is_black;
  reg start_pending;
  reg [`CNT_W-1:0] black_left;
  reg [`CNT_W-1:0] word_cnt;
  reg [`WORD_W-1:0] crc [0:`LANES-1];
  reg [`LANE_BUS_W-1:0] lanes_q;
  reg [`WORD_W-1:0] sync_q;
  wire act_a;
  wire act_b;
  wire any_act;
  wire [`ROW_W-1:0] start_row;
  wire [`ROW_W-1:0] end_row;
  wire [`ROW_W-1:0] hi_first;
  wire [`ROW_W-1:0] hi_last;
  wire [2:0] hi_id;
  wire [`WORD_W-1:0] id_word;
  wire [`WORD_W-1:0] begin_word;
  wire [`WORD_W-1:0] finish_word;
  wire [`WORD_W-1:0] train_lane;
  wire last_word;

  assign act_a = in_win(row, window_a_first_row, window_a_last_row);
  assign act_b = window_b_enable & in_win(row, window_b_first_row, window_b_last_row);
  assign any_act = act_a | act_b;
  assign start_row = (window_b_enable && window_b_first_row < window_a_first_row) ?
                     window_b_first_row : window_a_first_row;
  assign end_row = (window_b_enable && window_b_last_row > window_a_last_row) ?
                   window_b_last_row : window_a_last_row;
  // Markers follow the highest-numbered active window only
  assign hi_id = act_b ? `WIN_B_ID : `WIN_A_ID;
  assign hi_first = act_b ? window_b_first_row : window_a_first_row;
  assign hi_last = act_b ? window_b_last_row : window_a_last_row;

  // Marker and window number words for both modes
  assign id_word = narrow_mode ? {5'b00000, hi_id, 2'b00} : {7'b0000000, hi_id};
  assign begin_word = narrow_mode ?
    {2'b00, (row == hi_first) ? `KIND_FRAME_BEGIN : `KIND_LINE_BEGIN,
     frame_marker_ident_code[6:2]} :
    {(row == hi_first) ? `KIND_FRAME_BEGIN : `KIND_LINE_BEGIN, frame_marker_ident_code};
  assign finish_word = narrow_mode ?
    {2'b00, (row == hi_last) ? `KIND_FRAME_FINISH : `KIND_LINE_FINISH,
     frame_marker_ident_code[6:2]} :
    {(row == hi_last) ? `KIND_FRAME_FINISH : `KIND_LINE_FINISH, frame_marker_ident_code};
  assign train_lane = fmt(narrow_mode, train_pattern);
  assign last_word = (word_cnt == line_words - 1'b1);
  assign fifo_pop = tick & (state == S_DATA) & fifo_valid;

  //////////////////////////////////////////////////////////////////////////////
  // Line sequencer; lane and sync words change together on each word tick

  integer k;

  always @(posedge clk) begin
    if (srst) begin
      state <= S_IDLE;
      row <= {`ROW_W{1'b0}};
      is_black <= 1'b0;
      start_pending <= 1'b0;
      black_left <= {`CNT_W{1'b0}};
      word_cnt <= {`CNT_W{1'b0}};
      lanes_q <= {`LANE_BUS_W{1'b0}};
      sync_q <= {`WORD_W{1'b0}};
      for (k = 0; k < `LANES; k = k + 1) begin
        crc[k] <= `CRC_SEED;
      end
    end else if (ce) begin
      // A start that arrives while it is taken is kept, set wins
      if (frame_start) begin
        start_pending <= 1'b1;
      end else if (state == S_IDLE && tick && start_pending) begin
        start_pending <= 1'b0;
      end
      // Row search needs no word slot; skipped rows cost one clock each
      if (state == S_NEXT) begin
        if (row > end_row) begin
          state <= S_IDLE;
        end else if (any_act) begin
          state <= S_BEGIN;
        end else begin
          row <= row + 1'b1;
        end
      end
      if (tick) begin
        // Default slot: training on data lanes and training code on sync
        lanes_q <= {`LANES{train_lane}};
        sync_q <= fmt(narrow_mode, training_type_code);
        case (state)
          S_IDLE: begin
            if (start_pending) begin
              row <= start_row;
              word_cnt <= {`CNT_W{1'b0}};
              for (k = 0; k < `LANES; k = k + 1) begin
                crc[k] <= `CRC_SEED;
              end
              if (black_lines != {`CNT_W{1'b0}}) begin
                is_black <= 1'b1;
                black_left <= black_lines;
                state <= S_DATA;
              end else begin
                is_black <= 1'b0;
                state <= S_NEXT;
              end
            end
          end
          S_BEGIN: begin
            sync_q <= begin_word;
            state <= S_BID;
          end
          S_BID: begin
            sync_q <= id_word;
            word_cnt <= {`CNT_W{1'b0}};
            for (k = 0; k < `LANES; k = k + 1) begin
              crc[k] <= `CRC_SEED;
            end
            state <= S_DATA;
          end
          S_DATA: begin
            // An empty FIFO holds the line and fills the slot with training
            if (fifo_valid) begin
              for (k = 0; k < `LANES; k = k + 1) begin
                lanes_q[k*`WORD_W +: `WORD_W] <=
                  fmt(narrow_mode, fifo_data[k*`WORD_W +: `WORD_W]);
                crc[k] <= crc_step(crc[k], fmt(narrow_mode, fifo_data[k*`WORD_W +: `WORD_W]));
              end
              sync_q <= fmt(narrow_mode, is_black ? black_type_code : pixel_type_code);
              word_cnt <= word_cnt + 1'b1;
              if (last_word) begin
                state <= is_black ? S_CRC : S_FIN;
              end
            end
          end
          S_FIN: begin
            sync_q <= finish_word;
            state <= S_FID;
          end
          S_FID: begin
            sync_q <= id_word;
            state <= S_CRC;
          end
          S_CRC: begin
            for (k = 0; k < `LANES; k = k + 1) begin
              lanes_q[k*`WORD_W +: `WORD_W] <= fmt(narrow_mode, crc[k]);
              crc[k] <= `CRC_SEED;
            end
            sync_q <= fmt(narrow_mode, checksum_type_code);
            word_cnt <= {`CNT_W{1'b0}};
            if (is_black && black_left != {{(`CNT_W-1){1'b0}}, 1'b1}) begin
              black_left <= black_left - 1'b1;
              state <= S_DATA;
            end else begin
              if (!is_black) begin
                row <= row + 1'b1;
              end
              is_black <= 1'b0;
              black_left <= {`CNT_W{1'b0}};
              state <= S_NEXT;
            end
          end
          default: state <= state;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign lane0_word = lanes_q[9:0];
  assign lane1_word = lanes_q[19:10];
  assign lane2_word = lanes_q[29:20];
  assign lane3_word = lanes_q[39:30];
  assign sync_word = sync_q;
  assign frame_active = (state != S_IDLE);
  // Word depth is traded for rate only; the sequencer clock stays the same
  assign lane_rate_mbps = narrow_mode ? `RATE_NARROW_MBPS : `RATE_WIDE_MBPS;

endmodule // image_sync_channel_framer

// [testbench/image_sync_channel_framer_chk.sv]
`timescale 1ns/1ns
module image_sync_channel_framer_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs
  input wire logic word_clk,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [9:0] reg_wdata,
  input wire logic narrow_mode,
  // Outputs
  input wire logic [9:0] reg_rdata,
  input wire logic [9:0] lane0_word,
  input wire logic [9:0] lane3_word,
  input wire logic [9:0] sync_word,
  input wire logic word_strobe,
  input wire logic frame_active,
  input wire logic [9:0] lane_rate_mbps
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // Previous slot word, kept with the mode seen at the tick that ends it, not the mode it was made in
  logic [9:0] old_sync;
  logic old_nar;
  always_ff @(posedge clk) begin
    if (srst) begin
      old_sync <= 10'h000;
      old_nar <= 1'b0;
    end else if (word_strobe) begin
      old_sync <= sync_word;
      old_nar <= narrow_mode;
    end
  end
  wire old_mark = !old_nar && old_sync[9:7] inside {3'h1, 3'h2, 3'h5, 3'h6};
  ////////////////////////////////////////
  // Marker slot, then the slot after it
  sequence tick_s;
    word_strobe;
  endsequence
  sequence mark_done_s;
    tick_s ##1 old_mark;
  endsequence
  marker_then_id_a: assert property (mark_done_s |-> sync_word[9:3] == 7'h00)
    else $error("window number slot malformed");
  hold_words_a: assert property (!word_strobe |=> $stable(sync_word) && $stable(lane0_word))
    else $error("words moved without a tick");
  strobe_pulse_a: assert property (word_strobe |=> !word_strobe)
    else $error("tick longer than one cycle");
  tick_delay_a: assert property ($rose(word_clk) |-> ##[3:4] word_strobe)
    else $error("word clock edge gave no tick");
  idle_train_a: assert property (
    word_strobe && !frame_active && !narrow_mode |=>
    sync_word == 10'h3a6 && lane0_word == 10'h3a6 && lane3_word == 10'h3a6)
    else $error("idle slot is not training");
  narrow_width_a: assert property (
    word_strobe && narrow_mode |=> sync_word[9:8] == 2'h0 && lane0_word[9:8] == 2'h0)
    else $error("narrow word wider than 8 bits");
  pixel_frame_a: assert property (tick_s ##1 sync_word == 10'h035 |-> frame_active)
    else $error("pixel code outside a frame");
  rate_wide_a: assert property (!narrow_mode |-> lane_rate_mbps == 10'h26c)
    else $error("wide lane rate wrong");
  rate_narrow_a: assert property (narrow_mode |-> lane_rate_mbps == 10'h1f0)
    else $error("narrow lane rate wrong");
  ident_read_a: assert property (
    reg_write && reg_addr == 8'h83 ##1 reg_addr == 8'h83
    |=> reg_rdata == ($past(reg_wdata, 2) & 10'h07f))
    else $error("ident readback wrong");
endmodule // image_sync_channel_framer_chk

// [testbench/lane_rx_model.sv]
`timescale 1ns/1ns
module lane_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link words from the framer
  input wire logic word_strobe,
  input wire logic narrow_mode,
  input wire logic [9:0] lane0_word,
  input wire logic [9:0] lane1_word,
  input wire logic [9:0] lane2_word,
  input wire logic [9:0] lane3_word,
  input wire logic [9:0] sync_word
);
  logic tick_d;
  logic nar_d;
  logic [9:0] sync_q[$];
  logic [39:0] lane_q[$];
  // Slots are read a cycle after the tick, once the new words have landed;
  // the mode is kept from the tick so a mode switch never lets a training slot in
  always @(posedge clk) begin
    tick_d <= word_strobe && !srst;
    nar_d <= narrow_mode;
    if (tick_d && sync_word !== (nar_d ? 10'h0e9 : 10'h3a6)) begin
      sync_q.push_back(sync_word);
      lane_q.push_back({lane3_word, lane2_word, lane1_word, lane0_word});
    end
  end
endmodule // lane_rx_model

// [testbench/image_sync_channel_framer_test.sv]
`timescale 1ns/1ns
module image_sync_channel_framer_test;
  logic clk, srst, word_clk, reg_write, narrow_mode, frame_start, window_b_enable;
  logic pixel_valid, pixel_ready, word_strobe, frame_active;
  logic [7:0] reg_addr;
  logic [9:0] reg_wdata, reg_rdata, black_lines, line_words, lane_rate_mbps, sync_word;
  logic [9:0] lane0_word, lane1_word, lane2_word, lane3_word;
  logic [10:0] window_a_first_row, window_a_last_row, window_b_first_row, window_b_last_row;
  logic [39:0] pixel_data;
  logic [6:0] ident;
  logic [9:0] exp_q[$];
  logic [39:0] px_q[$], px_w;
  logic [9:0] crc_m[4];
  logic [9:0] rst_val[6] = '{10'h3a6, 10'h02a, 10'h015, 10'h035, 10'h059, 10'h3a6};
  integer seed = 63;
  integer error_cnt = 0;
  integer cmp_count = 0;
  integer k;
  ////////////////////////////////////////
  // Device and far-side receiver; enable tied high, freezing is not exercised
  image_sync_channel_framer u_image_sync_channel_framer (
    .clk(clk), .ce(1'b1), .srst(srst), .word_clk(word_clk),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .narrow_mode(narrow_mode), .frame_start(frame_start), .black_lines(black_lines),
    .line_words(line_words), .window_b_enable(window_b_enable),
    .window_a_first_row(window_a_first_row), .window_a_last_row(window_a_last_row),
    .window_b_first_row(window_b_first_row), .window_b_last_row(window_b_last_row),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .pixel_data(pixel_data),
    .lane0_word(lane0_word), .lane1_word(lane1_word), .lane2_word(lane2_word),
    .lane3_word(lane3_word), .sync_word(sync_word), .word_strobe(word_strobe),
    .frame_active(frame_active), .lane_rate_mbps(lane_rate_mbps));
  lane_rx_model rx (.clk(clk), .srst(srst), .word_strobe(word_strobe),
    .narrow_mode(narrow_mode), .lane0_word(lane0_word), .lane1_word(lane1_word),
    .lane2_word(lane2_word), .lane3_word(lane3_word), .sync_word(sync_word));
  // System clock and an unrelated word clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    word_clk = 1'b0;
    #7;
    forever #80 word_clk = ~word_clk;
  end
  // Pixel source: after every accepted word, shift the lanes up one and put a fresh random word on lane 0
  always @(posedge clk) begin
    if (!srst && pixel_valid && pixel_ready) begin
      px_q.push_back(pixel_data);
      pixel_data <= {pixel_data[29:0], 10'($random(seed))};
    end
  end
  ////////////////////////////////////////
  task chk(input [9:0] seen, input [9:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task lost;
    error_cnt = error_cnt + 1;
    $display("[ERR] %0t wait ran out", $time);
    end_sim;
  endtask
  // Register port: one-cycle write strobe, read answer one edge after the index
  task wr(input [7:0] a, input [9:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task rd(input [7:0] a, input [9:0] e);
    reg_addr <= a;
    repeat (3) @(posedge clk);
    chk(reg_rdata, e);
  endtask
  ////////////////////////////////////////
  // Expected sync words in the current mode
  function automatic logic [9:0] fmt(input logic [9:0] v);
    return narrow_mode ? {2'h0, v[9:2]} : v;
  endfunction
  function automatic logic [9:0] mark(input logic [2:0] kd);
    return narrow_mode ? {2'h0, kd, ident[6:2]} : {kd, ident};
  endfunction
  function automatic logic [9:0] wid(input logic w);
    return narrow_mode ? {7'h00, w, 2'h0} : {9'h000, w};
  endfunction
  // Lane checksum step: seed all ones, MSB first over the word as sent
  function automatic logic [9:0] crc_of(input logic [9:0] c, input logic [9:0] w);
    for (int b = 9; b >= 0; b--) c = {c[8:0], 1'b0} ^ ((c[9] ^ w[b]) ? 10'h233 : 10'h000);
    return c;
  endfunction
  task build;
    integer b, r, i, lo, top, f, l;
    logic ain, bin;
    for (b = 0; b < black_lines; b++) begin
      for (i = 0; i < line_words; i++) exp_q.push_back(fmt(10'h015));
      exp_q.push_back(fmt(10'h059));
    end
    lo = window_a_first_row;
    top = window_a_last_row;
    if (window_b_enable && window_b_first_row < lo) lo = window_b_first_row;
    if (window_b_enable && window_b_last_row > top) top = window_b_last_row;
    for (r = lo; r <= top; r++) begin
      ain = r >= window_a_first_row && r <= window_a_last_row;
      bin = window_b_enable && r >= window_b_first_row && r <= window_b_last_row;
      f = bin ? window_b_first_row : window_a_first_row;
      l = bin ? window_b_last_row : window_a_last_row;
      if (ain || bin) begin
        exp_q.push_back(mark(r == f ? 3'h5 : 3'h1));
        exp_q.push_back(wid(bin));
        for (i = 0; i < line_words; i++) exp_q.push_back(fmt(10'h035));
        exp_q.push_back(mark(r == l ? 3'h6 : 3'h2));
        exp_q.push_back(wid(bin));
        exp_q.push_back(fmt(10'h059));
      end
    end
  endtask
  // One frame (two if rep is 2), with the pixel stream stalled in mid-frame
  task run(input nm, input [9:0] b, input [9:0] n, input [10:0] a0, input [10:0] a1,
           input be, input [10:0] b0, input [10:0] b1, input integer rep);
    integer i, j;
    narrow_mode <= nm;
    black_lines <= b;
    line_words <= n;
    window_a_first_row <= a0;
    window_a_last_row <= a1;
    window_b_enable <= be;
    window_b_first_row <= b0;
    window_b_last_row <= b1;
    @(posedge clk);
    repeat (rep) build;
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    for (i = 0; i < 200 && frame_active !== 1'b1; i++) @(posedge clk);
    if (frame_active !== 1'b1) lost;
    pixel_valid <= 1'b0;
    frame_start <= rep > 1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (150) @(posedge clk);
    pixel_valid <= 1'b1;
    for (i = 0; i < 30000 && rx.sync_q.size() < exp_q.size(); i++) @(posedge clk);
    if (rx.sync_q.size() < exp_q.size()) lost;
    repeat (300) @(posedge clk);
    chk(10'(rx.sync_q.size()), 10'(exp_q.size()));
    for (j = 0; j < 4; j++) crc_m[j] = 10'h3ff;
    for (i = 0; i < exp_q.size(); i++) begin
      chk(rx.sync_q[i], exp_q[i]);
      if (exp_q[i] == fmt(10'h015) || exp_q[i] == fmt(10'h035)) begin
        px_w = px_q.pop_front();
        for (j = 0; j < 4; j++) begin
          chk(rx.lane_q[i][j*10 +: 10], fmt(px_w[j*10 +: 10]));
          crc_m[j] = crc_of(crc_m[j], fmt(px_w[j*10 +: 10]));
        end
      end else if (exp_q[i] == fmt(10'h059)) begin
        for (j = 0; j < 4; j++) begin
          chk(rx.lane_q[i][j*10 +: 10], fmt(crc_m[j]));
          crc_m[j] = 10'h3ff;
        end
      end
    end
    exp_q.delete();
    rx.sync_q.delete();
    rx.lane_q.delete();
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'b1;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 10'h000;
    narrow_mode = 1'b0;
    frame_start = 1'b0;
    black_lines = 10'h000;
    line_words = 10'h001;
    window_b_enable = 1'b0;
    window_a_first_row = 11'h000;
    window_a_last_row = 11'h000;
    window_b_first_row = 11'h000;
    window_b_last_row = 11'h000;
    pixel_valid = 1'b0;
    pixel_data = 40'h00_0000_0000;
    ident = 7'h2a;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    pixel_valid <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 6; k++) rd(8'h82 + 8'(k), rst_val[k]);
    rd(8'h00, 10'h000);
    chk({9'h000, pixel_ready}, 10'h000);
    ident = 7'($random(seed));
    wr(8'h83, {3'h0, ident});
    rd(8'h83, {3'h0, ident});
    run(1'b0, 10'h001, 10'h002, 11'h003, 11'h005, 1'b0, 11'h000, 11'h000, 2);
    run(1'b0, 10'h000, 10'h001, 11'h002, 11'h005, 1'b1, 11'h004, 11'h007, 1);
    run(1'b1, 10'h001, 10'h001, 11'h000, 11'h000, 1'b1, 11'h002, 11'h003, 1);
    run(1'b1, 10'h000, 10'h003, 11'h002, 11'h002, 1'b1, 11'h002, 11'h002, 1);
    end_sim;
  end
endmodule // image_sync_channel_framer_test

bind image_sync_channel_framer image_sync_channel_framer_chk u_chk (
  .clk(clk), .srst(srst), .word_clk(word_clk), .reg_write(reg_write), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .narrow_mode(narrow_mode), .reg_rdata(reg_rdata),
  .lane0_word(lane0_word), .lane3_word(lane3_word), .sync_word(sync_word),
  .word_strobe(word_strobe), .frame_active(frame_active), .lane_rate_mbps(lane_rate_mbps));
